// ### rtl/tck_counter.sv
// module: periodic tick counter top, register slave, prescaler and match logic
//
// Behaviour
// [R01] 16-bit limit in two bytes; on match count restarts at zero, flag sets
// [R02] limit zero sets the flag on every prescaler tick
// [R03] count readable as two bytes; writes to them are ignored
// [R04] count clears on reset, limit write, or changed source or divider
// [R05] after reset: stopped, count and limit zero, divider off, external source
// [R06] counting starts with non-zero divider code; zero halts the prescaler
// [R07] source 00 external, 01 slow 1 kHz, 10 and 11 bus clock
// [R08] writing a different source clears prescaler and count
// [R09] writing a different divider clears prescaler and count
// [R10] divider 0 is off; slow source codes 6 and 7 give 100 ms, 1 s
// [R11] count steps once per prescaler tick up to the limit, then wraps
// [R12] flag sets on the step from the limit back to zero
// [R13] new limit is buffered, loaded on wrap or non-zero divider select
// [R14] interrupt asserted while flag and its enable are both set
// [R15] writing one to the flag bit clears it; zero is ignored
// [R16] with output enabled, pin inverts on every wrap
// [R17] any limit from 0000 to FFFF is accepted
// [R18] divides 1..64 for even sources, 128..2048, 100, 1000 for odd
// [R19] oscillator edges are synchronised before they reach the counter
`timescale 1ns/1ps
module tck_counter
(
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    // register port
    input  wire logic [tck_pkg::ADDR_W-1:0]    addr,
    input  wire logic [tck_pkg::DATA_W-1:0]    wdata,
    input  wire logic                          wr_en,
    input  wire logic                          rd_en,
    output logic      [tck_pkg::DATA_W-1:0]    rdata,
    // oscillator pins
    input  wire logic                          external_osc,
    input  wire logic                          internal_slow_osc,
    // outputs
    output logic                               toggle_out,
    output logic                               irq
);
    import tck_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [CNT_W-1:0]  count_q;
    logic [CNT_W-1:0]  count_d;
    logic [CNT_W-1:0]  limit_buf_q;
    logic [CNT_W-1:0]  limit_buf_d;
    logic [CNT_W-1:0]  limit_q;
    logic [CNT_W-1:0]  limit_d;
    logic [1:0]        src_q;
    logic [2:0]        div_q;
    logic              match_flag_q;
    logic              match_flag_d;
    logic              irq_en_q;
    logic              tog_en_q;
    logic              stat_q;
    logic              stat_d;
    logic              mask_q;
    logic [DATA_W-1:0] rd_mux;
    logic              ext_rise;
    logic              slow_rise;

    tck_ps_if ps_bus ();

    ////////////////////////////////////////////////////////////////////////////
    // oscillator synchronisers
    tck_sync_edge u_ext_sync
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (external_osc),
        .rise    (ext_rise)
    ); // R19

    tck_sync_edge u_slow_sync
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin     (internal_slow_osc),
        .rise    (slow_rise)
    ); // R19

    ////////////////////////////////////////////////////////////////////////////
    // address decode
    wire logic wr_ctrl   = wr_en & tck_hit(addr, IDX_CTRL);
    wire logic wr_cfg    = wr_en & tck_hit(addr, IDX_CFG);
    wire logic wr_lim_hi = wr_en & tck_hit(addr, IDX_LIMIT_HI);
    wire logic wr_lim_lo = wr_en & tck_hit(addr, IDX_LIMIT_LO);
    wire logic wr_cnt    = wr_en & (tck_hit(addr, IDX_COUNT_HI)
                                    | tck_hit(addr, IDX_COUNT_LO));
    wire logic wr_mask   = wr_en & tck_hit(addr, IDX_IRQ_MASK);
    wire logic rd_stat   = rd_en & tck_hit(addr, IDX_IRQ_STAT);
    wire logic wr_lim    = wr_lim_hi | wr_lim_lo;

    // new source and divider fields as written
    wire logic [1:0] src_w = wdata[SRC_HI:SRC_LO];
    wire logic [2:0] div_w = wdata[DIV_HI:DIV_LO];

    // a config write that changes source or divider
    wire logic cfg_change = wr_cfg & ((src_w != src_q) | (div_w != div_q)); // R08 R09

    // non-zero divider selection reloads the compare value
    wire logic div_start = wr_cfg & (div_w != DIV_OFF); // R13

    // write causes that zero the count: limit write or config change; wrap and reset zero it separately
    wire logic count_clear = wr_lim | cfg_change; // R04

    ////////////////////////////////////////////////////////////////////////////
    // source selection into the prescaler
    assign ps_bus.src_tick = (src_q == SRC_EXT)  ? ext_rise :
                             (src_q == SRC_SLOW) ? slow_rise :
                             1'b1; // R07
    assign ps_bus.clear    = cfg_change; // R08 R09
    assign ps_bus.div_sel  = div_q;
    assign ps_bus.src_bit0 = src_q[0];

    tck_prescaler u_prescaler
    (
        .clk     (clk),
        .sys_rst (sys_rst),
        .p       (ps_bus.ps)
    );

    wire logic ps_tick = ps_bus.ps_tick;

    ////////////////////////////////////////////////////////////////////////////
    // compare and wrap
    wire logic at_limit = count_q == limit_q; // R17
    wire logic wrap     = ps_tick & at_limit & ~count_clear; // R01 R02 R12

    // count next value, clear beats stepping
    assign count_d = count_clear ? '0 :
                     ~ps_tick    ? count_q :
                     at_limit    ? '0 : count_q + 16'h0001; // R01 R11

    // limit buffer takes bytes as software writes them
    assign limit_buf_d = {wr_lim_hi ? wdata : limit_buf_q[15:8],
                          wr_lim_lo ? wdata : limit_buf_q[7:0]}; // R01

    // active compare value loads on wrap or divider start
    assign limit_d = (wrap | div_start) ? limit_buf_d : limit_q; // R13

    ////////////////////////////////////////////////////////////////////////////
    // flags, set wins over clear
    assign match_flag_d = wrap | (match_flag_q & ~(wr_ctrl & wdata[FLAG_BIT])); // R12 R15
    assign stat_d       = wrap | (stat_q & ~rd_stat);

    ////////////////////////////////////////////////////////////////////////////
    // read data
    assign rd_mux =
        tck_hit(addr, IDX_CTRL)     ? {match_flag_q, irq_en_q, 1'b0, tog_en_q, 4'h0} :
        tck_hit(addr, IDX_CFG)      ? {src_q, 3'h0, div_q} :
        tck_hit(addr, IDX_LIMIT_HI) ? limit_buf_q[15:8] :
        tck_hit(addr, IDX_LIMIT_LO) ? limit_buf_q[7:0] :
        tck_hit(addr, IDX_COUNT_HI) ? count_q[15:8] :
        tck_hit(addr, IDX_COUNT_LO) ? count_q[7:0] :
        tck_hit(addr, IDX_IRQ_STAT) ? {7'h00, stat_q} :
        tck_hit(addr, IDX_IRQ_MASK) ? {7'h00, mask_q} :
        BYTE_RST; // R03

    ////////////////////////////////////////////////////////////////////////////
    // counter and compare registers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            count_q     <= '0; // R04 R05
            limit_buf_q <= LIMIT_RST; // R05
            limit_q     <= LIMIT_RST;
        end
        else
        begin
            count_q     <= count_d; // R03 R11
            limit_buf_q <= limit_buf_d;
            limit_q     <= limit_d;
        end
    end

    // configuration registers, only differences restart the chain
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            src_q <= SRC_EXT; // R05
            div_q <= DIV_OFF; // R05
        end
        else if (wr_cfg)
        begin
            src_q <= src_w;
            div_q <= div_w; // R06
        end
    end

    // control bits and flag
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            match_flag_q <= 1'b0;
            irq_en_q     <= 1'b0;
            tog_en_q     <= 1'b0;
        end
        else
        begin
            match_flag_q <= match_flag_d;
            if (wr_ctrl)
            begin
                irq_en_q <= wdata[IRQ_EN_BIT];
                tog_en_q <= wdata[TOG_EN_BIT];
            end
        end
    end

    // sticky event status and its mask
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            stat_q <= 1'b0;
            mask_q <= 1'b0;
        end
        else
        begin
            stat_q <= stat_d;
            if (wr_mask)
                mask_q <= wdata[EVT_MATCH];
        end
    end

    // outputs straight from flops
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rdata      <= BYTE_RST;
            toggle_out <= 1'b0;
            irq        <= 1'b0;
        end
        else
        begin
            rdata      <= rd_en ? rd_mux : BYTE_RST;
            toggle_out <= toggle_out ^ (wrap & tog_en_q); // R16
            irq        <= (match_flag_q & irq_en_q) | (stat_q & mask_q); // R14
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_count_wraps: assert property (ps_tick && at_limit && !count_clear |=> count_q == '0) // R11
        else $error("count did not wrap at limit");

    a_flag_on_wrap: assert property (wrap |=> match_flag_q && $past(count_q) == $past(limit_q)) // R12
        else $error("flag missing after wrap");

    a_zero_limit: assert property (ps_tick && limit_q == '0 && !count_clear |=> match_flag_q) // R02
        else $error("zero limit did not flag");

    a_count_ro: assert property (wr_cnt && !ps_tick |=> $stable(count_q)) // R03
        else $error("count changed on write");

    a_limit_clear: assert property (wr_lim |=> count_q == '0) // R04
        else $error("limit write left count");

    a_cfg_clear: assert property (cfg_change |=> count_q == '0 ##1 count_q <= 16'h0001) // R08
        else $error("config change did not restart");

    a_limit_load: assert property (wrap && !wr_lim |=> limit_q == $past(limit_buf_q)) // R13
        else $error("limit not loaded on wrap");

    a_limit_hold: assert property (!wrap && !div_start |=> $stable(limit_q)) // R13
        else $error("limit loaded early");

    a_irq_level: assert property (match_flag_q && irq_en_q |=> irq) // R14
        else $error("irq missing");

    a_flag_clear: assert property (wr_ctrl && wdata[FLAG_BIT] && !wrap |=> !match_flag_q) // R15
        else $error("flag not cleared");

    a_pin_toggle: assert property (wrap && tog_en_q |=> toggle_out != $past(toggle_out)) // R16
        else $error("pin did not toggle");

    a_pin_hold: assert property (!(wrap && tog_en_q) |=> $stable(toggle_out)) // R16
        else $error("pin toggled without wrap");

    a_off_no_step: assert property (div_q == DIV_OFF && !count_clear |=> $stable(count_q)) // R06
        else $error("count moved while off");

    a_off_no_tick: assert property (div_q == DIV_OFF |-> !ps_tick) // R06
        else $error("prescaler tick while off");

    a_count_step: assert property (ps_tick && !at_limit && !count_clear |=> // R11
        count_q == $past(count_q) + 16'h0001)
        else $error("count did not step by one");

    a_limit_start: assert property (div_start && !wr_lim |=> // R13
        limit_q == $past(limit_buf_q))
        else $error("limit not loaded on divider start");

    a_flag_hold: assert property (!wrap && !(wr_ctrl && wdata[FLAG_BIT]) |=> // R15
        $stable(match_flag_q))
        else $error("flag changed without cause");

    // divider 1 on bus clock source 10 ticks every cycle
    a_bus_rate: assert property (src_q[1] && !src_q[0] && div_q == 3'h1 && !cfg_change |=> // R07
        ps_tick)
        else $error("bus clock source not ticking");

    // synchronised oscillator edges are single-cycle pulses
    a_ext_pulse: assert property (ext_rise |=> !ext_rise) // R19
        else $error("external edge pulse too long");

    a_slow_pulse: assert property (slow_rise |=> !slow_rise) // R19
        else $error("slow edge pulse too long");

    ////////////////////////////////////////////////////////////////////////////
    // status, interrupt and bus checks
    a_stat_set: assert property (wrap |=> stat_q) // R12
        else $error("status not set on wrap");

    a_stat_clear: assert property (rd_stat && !wrap |=> !stat_q) // R14
        else $error("status not cleared by read");

    a_irq_stat: assert property (stat_q && mask_q |=> irq) // R14
        else $error("masked status gave no irq");

    a_irq_quiet: assert property (!match_flag_q && !stat_q |=> !irq) // R14
        else $error("irq without cause");

    a_rdata_idle: assert property (!rd_en |=> rdata == BYTE_RST) // R03
        else $error("read data left standing");

    a_rdata_cnt_hi: assert property (rd_en && tck_hit(addr, IDX_COUNT_HI) |=> // R03
        rdata == ($past(count_q) >> 8))
        else $error("count high byte read wrong");

    a_rdata_cnt_lo: assert property (rd_en && tck_hit(addr, IDX_COUNT_LO) |=> // R03
        rdata == ($past(count_q) & 16'h00FF))
        else $error("count low byte read wrong");

    // reset state, checked while reset is held
    a_reset_state: assert property (disable iff (1'b0) sys_rst |=> count_q == '0 && // R05
        limit_q == LIMIT_RST && src_q == SRC_EXT && div_q == DIV_OFF && !toggle_out)
        else $error("reset state wrong");

endmodule : tck_counter

// ### rtl/tck_pkg.sv
// package: register map, field layout, reset values and divider table of the tick counter
package tck_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // bus, counter and prescaler widths
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 16;
    localparam int PS_W   = 11;

    ////////////////////////////////////////////////////////////////////////////
    // register indices, byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_CTRL      = 16'h306A;
    localparam logic [ADDR_W-1:0] IDX_CFG       = 16'h306B;
    localparam logic [ADDR_W-1:0] IDX_LIMIT_HI  = 16'h306C;
    localparam logic [ADDR_W-1:0] IDX_LIMIT_LO  = 16'h306D;
    localparam logic [ADDR_W-1:0] IDX_COUNT_HI  = 16'h306E;
    localparam logic [ADDR_W-1:0] IDX_COUNT_LO  = 16'h306F;
    localparam logic [ADDR_W-1:0] IDX_IRQ_STAT  = 16'h3070;
    localparam logic [ADDR_W-1:0] IDX_IRQ_MASK  = 16'h3071;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int FLAG_BIT    = 7;
    localparam int IRQ_EN_BIT  = 6;
    localparam int TOG_EN_BIT  = 4;
    localparam int SRC_HI      = 7;
    localparam int SRC_LO      = 6;
    localparam int DIV_HI      = 2;
    localparam int DIV_LO      = 0;
    localparam int EVT_MATCH   = 0;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and codes
    localparam logic [CNT_W-1:0]  LIMIT_RST = 16'h0000;
    localparam logic [1:0]        SRC_EXT   = 2'h0;
    localparam logic [1:0]        SRC_SLOW  = 2'h1;
    localparam logic [2:0]        DIV_OFF   = 3'h0;
    localparam logic [DATA_W-1:0] BYTE_RST  = 8'h00;

    // true when a byte address selects the given register index
    function automatic logic tck_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] idx);
        return addr == {idx[ADDR_W-3:0], 2'h0};
    endfunction : tck_hit

    // last prescaler count: divide-by minus one
    function automatic logic [PS_W-1:0] tck_div_last(input logic       src0,
                                                     input logic [2:0] code);
        logic [PS_W-1:0] r;
        r = 11'h000;
        unique case (code)
            3'h0: r = 11'h000;
            3'h1: r = src0 ? 11'h07F : 11'h000;
            3'h2: r = src0 ? 11'h0FF : 11'h001;
            3'h3: r = src0 ? 11'h1FF : 11'h003;
            3'h4: r = src0 ? 11'h3FF : 11'h007;
            3'h5: r = src0 ? 11'h7FF : 11'h00F;
            3'h6: r = src0 ? 11'h063 : 11'h01F;
            3'h7: r = src0 ? 11'h3E7 : 11'h03F;
        endcase
        return r;
    endfunction : tck_div_last

endpackage : tck_pkg

// ### rtl/tck_prescaler.sv
// module: binary and decimal prescaler driven by source tick enables
`timescale 1ns/1ps
module tck_prescaler
(
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // control and divided tick
    tck_ps_if.ps      p
);
    import tck_pkg::*;

    logic [PS_W-1:0] cnt_q;
    logic [PS_W-1:0] cnt_d;
    logic            tick_d;
    wire  logic      run      = p.div_sel != DIV_OFF; // R06
    wire  logic [PS_W-1:0] last_v = tck_div_last(p.src_bit0, p.div_sel); // R18
    wire  logic      at_last  = cnt_q == last_v;

    // count source ticks, pulse on the last one
    assign tick_d = run & p.src_tick & at_last & ~p.clear; // R10
    assign cnt_d  = (p.clear | ~run) ? '0 :
                    ~p.src_tick ? cnt_q :
                    at_last ? '0 : cnt_q + 11'h001;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cnt_q     <= '0;
            p.ps_tick <= 1'b0;
        end
        else
        begin
            cnt_q     <= cnt_d; // R08 R09
            p.ps_tick <= tick_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_halt_when_off: assert property (p.div_sel == DIV_OFF |=> !p.ps_tick) // R06
        else $error("prescaler ticked while off");
    a_clear_zeroes: assert property (p.clear |=> cnt_q == '0 && !p.ps_tick) // R08
        else $error("prescaler not cleared");
endmodule : tck_prescaler

// ### rtl/tck_ps_if.sv
// interface: source tick and control into the prescaler, divided tick back
`timescale 1ns/1ps
interface tck_ps_if;
    logic       src_tick;
    logic       clear;
    logic [2:0] div_sel;
    logic       src_bit0;
    logic       ps_tick;

    modport ctl (output src_tick, output clear, output div_sel, output src_bit0,
                 input ps_tick);
    modport ps  (input src_tick, input clear, input div_sel, input src_bit0,
                 output ps_tick);
endinterface : tck_ps_if

// ### rtl/tck_sync_edge.sv
// module: two-flop synchroniser with rising-edge pulse for an oscillator pin
`timescale 1ns/1ps
module tck_sync_edge
(
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // pin and edge
    input  wire logic pin,
    output logic      rise
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // meta_q feeds sync_q only
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
            rise   <= 1'b0;
        end
        else
        begin
            meta_q <= pin;
            sync_q <= meta_q;
            last_q <= sync_q;
            rise   <= sync_q & ~last_q;
        end
    end
endmodule : tck_sync_edge

// ### testbench/testbench.sv
// testbench: register-level tests of the periodic tick counter
`timescale 1ns/1ps
module testbench;
    import tck_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // signals and bookkeeping
    logic              clk;
    logic              sys_rst;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr_en;
    logic              rd_en;
    logic [DATA_W-1:0] rdata;
    logic              external_osc;
    logic              internal_slow_osc;
    logic              toggle_out;
    logic              irq;
    int                bad_count;
    int                n_compared;
    int                cycles;
    int                per;
    logic [ADDR_W-1:0] rst_idx [7] = '{IDX_CTRL, IDX_CFG, IDX_LIMIT_HI, IDX_LIMIT_LO,
                                       IDX_COUNT_HI, IDX_COUNT_LO, 16'h3075};

    // design under test
    tck_counter i_tck_counter
    (
        .clk               (clk),
        .sys_rst           (sys_rst),
        .addr              (addr),
        .wdata             (wdata),
        .wr_en             (wr_en),
        .rd_en             (rd_en),
        .rdata             (rdata),
        .external_osc      (external_osc),
        .internal_slow_osc (internal_slow_osc),
        .toggle_out        (toggle_out),
        .irq               (irq)
    );

    // 125 MHz clock
    initial clk = 1'b0;
    always #4 clk = ~clk;

    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            bad_count++;
            $display("mismatch at %0t: cycles %h expected below %h", $time, cycles, 60000);
            report_and_stop;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus and pin tasks
    function automatic logic [ADDR_W-1:0] baddr(input logic [ADDR_W-1:0] idx);
        return {idx[ADDR_W-3:0], 2'h0};
    endfunction : baddr

    task automatic wr(input logic [ADDR_W-1:0] idx, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr  <= baddr(idx);
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    // read data lands in the cycle after the strobe edge
    task automatic rd(input logic [ADDR_W-1:0] idx, output logic [DATA_W-1:0] d);
        @(posedge clk);
        addr  <= baddr(idx);
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_val

    task automatic chk_reg(input logic [ADDR_W-1:0] idx, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] d;
        rd(idx, d);
        chk_val({8'h00, d}, {8'h00, exp}, "register");
    endtask : chk_reg

    task automatic chk_cnt(input logic [CNT_W-1:0] exp);
        logic [DATA_W-1:0] h;
        logic [DATA_W-1:0] l;
        rd(IDX_COUNT_HI, h);
        rd(IDX_COUNT_LO, l);
        chk_val({h, l}, exp, "count");
    endtask : chk_cnt

    // oscillator edges spaced well beyond the synchroniser latency
    task automatic pulse(input logic slow, input int n);
        repeat (n)
        begin
            @(posedge clk);
            if (slow)
                internal_slow_osc <= 1'b1;
            else
                external_osc <= 1'b1;
            repeat (4) @(posedge clk);
            internal_slow_osc <= 1'b0;
            external_osc      <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask : pulse

    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    // cycles until the toggle pin changes, bounded
    task automatic wait_tog(output int n);
        logic prev;
        n    = 0;
        prev = toggle_out;
        while (toggle_out === prev && n < 1000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_tog

    task automatic report_and_stop;
        $display("counts: %0d compared, %0d mismatched", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////////
    // test sequence
    initial
    begin
        sys_rst           = 1'b1;
        addr              = '0;
        wdata             = '0;
        wr_en             = 1'b0;
        rd_en             = 1'b0;
        external_osc      = 1'b0;
        internal_slow_osc = 1'b0;
        bad_count         = 0;
        n_compared        = 0;
        cycles            = 0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;

        // reset values, unmapped address last
        foreach (rst_idx[i]) chk_reg(rst_idx[i], BYTE_RST);
        chk_val({15'h0, toggle_out}, 16'h0000, "toggle");
        $display("test reset done");

        // counting from the external and slow pins, clears and selects
        wr(IDX_LIMIT_HI, 8'hFF);
        wr(IDX_LIMIT_LO, 8'hFF);
        wr(IDX_CFG, 8'h01);
        pulse(1'b0, 5);
        chk_cnt(16'h0005);
        wr(IDX_COUNT_HI, 8'hAA);
        wr(IDX_COUNT_LO, 8'hAA);
        chk_cnt(16'h0005);
        wr(IDX_CFG, 8'h01);
        chk_cnt(16'h0005);
        wr(IDX_LIMIT_LO, 8'hFF);
        chk_cnt(16'h0000);
        pulse(1'b0, 3);
        wr(IDX_CFG, 8'h03);
        chk_cnt(16'h0000);
        pulse(1'b0, 8);
        chk_cnt(16'h0002);
        wr(IDX_CFG, 8'h43);
        chk_cnt(16'h0000);
        pulse(1'b0, 4);
        chk_cnt(16'h0000);
        wr(IDX_CFG, 8'h46);
        pulse(1'b1, 99);
        chk_cnt(16'h0000);
        pulse(1'b1, 1);
        chk_cnt(16'h0001);
        wr(IDX_CFG, 8'h00);
        pulse(1'b0, 4);
        chk_cnt(16'h0000);
        $display("test sources done");

        // wrap, buffered limit, flag and toggle pin
        wr(IDX_LIMIT_HI, 8'h00);
        wr(IDX_LIMIT_LO, 8'h02);
        wr(IDX_CFG, 8'h01);
        wr(IDX_CTRL, 8'h10);
        wr(IDX_LIMIT_LO, 8'h05);
        pulse(1'b0, 3);
        chk_cnt(16'h0000);
        chk_reg(IDX_CTRL, 8'h90);
        chk_val({15'h0, toggle_out}, 16'h0001, "toggle");
        pulse(1'b0, 5);
        chk_cnt(16'h0005);
        pulse(1'b0, 1);
        chk_cnt(16'h0000);
        chk_val({15'h0, toggle_out}, 16'h0000, "toggle");
        $display("test wrap done");

        // zero limit, flag clearing and interrupt
        wr(IDX_LIMIT_LO, 8'h00);
        wr(IDX_CFG, 8'h01);
        wr(IDX_CTRL, 8'h90);
        chk_reg(IDX_CTRL, 8'h10);
        pulse(1'b0, 1);
        chk_reg(IDX_CTRL, 8'h90);
        chk_cnt(16'h0000);
        wr(IDX_CTRL, 8'h10);
        chk_reg(IDX_CTRL, 8'h90);
        wr(IDX_CTRL, 8'h90);
        chk_reg(IDX_CTRL, 8'h10);
        pulse(1'b0, 1);
        wr(IDX_CTRL, 8'h50);
        settle;
        chk_val({15'h0, irq}, 16'h0001, "irq");
        chk_reg(IDX_CTRL, 8'hD0);
        wr(IDX_CTRL, 8'hD0);
        chk_reg(IDX_CTRL, 8'h50);
        settle;
        chk_val({15'h0, irq}, 16'h0000, "irq");
        // sticky status with mask
        wr(IDX_CTRL, 8'h00);
        wr(IDX_IRQ_MASK, 8'h01);
        chk_reg(IDX_IRQ_STAT, 8'h01);
        settle;
        chk_val({15'h0, irq}, 16'h0000, "irq");
        pulse(1'b0, 1);
        settle;
        chk_val({15'h0, irq}, 16'h0001, "irq");
        chk_reg(IDX_IRQ_STAT, 8'h01);
        settle;
        chk_val({15'h0, irq}, 16'h0000, "irq");
        chk_reg(IDX_IRQ_MASK, 8'h01);
        wr(IDX_IRQ_MASK, 8'h00);
        $display("test flag done");

        // bus clock sources, period between pin toggles
        wr(IDX_LIMIT_LO, 8'h05);
        wr(IDX_CTRL, 8'h10);
        wr(IDX_CFG, 8'h81);
        wait_tog(per);
        wait_tog(per);
        chk_val(per[15:0], 16'h0006, "period");
        wr(IDX_CFG, 8'hC1);
        wait_tog(per);
        wait_tog(per);
        chk_val(per[15:0], 16'h0300, "period");
        $display("test bus clock done");
        report_and_stop;
    end

endmodule : testbench
